// ---- psc_consts.svh ----
// Constants for the printer status and command port.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
// ==========================================================
// Register map (byte addresses)
`define PSC_ADDR_CTRL 8'h00
`define PSC_ADDR_STAT 8'h04
`define PSC_ADDR_CMD 8'h08
`define PSC_ADDR_TIME 8'h0C
// ==========================================================
// Control bit positions
`define PSC_CTRL_POWER_OK 0
`define PSC_CTRL_RIB_EXH 1
`define PSC_CTRL_MALF 2
// ==========================================================
// Status bit positions
`define PSC_ST_CHAR_RDY 0
`define PSC_ST_CARR_RDY 1
`define PSC_ST_PAPR_RDY 2
`define PSC_ST_PAPL_RDY 3
`define PSC_ST_PRN_RDY 4
`define PSC_ST_FAULT 5
`define PSC_ST_RIB_UP 6
`define PSC_ST_RESTORE 7
// ==========================================================
// Data line fields
`define PSC_DIR_BIT 6
`define PSC_CHAR_MSB 6
`define PSC_CARR_MAX 12'h07FF
`define PSC_PAPR_MAX 12'h03FF
// ==========================================================
// Timing
`define PSC_CLK_MHZ 40
`define PSC_RESTORE_MIN_NS 500
`define PSC_RESTORE_MIN_CYC ((`PSC_RESTORE_MIN_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_STEP_CYC_DEF 16'h0004
`define PSC_AXI_OKAY 2'b00
`define PSC_AXI_SLVERR 2'b10
`endif

// ---- psc_pkg.sv ----
// Types for the printer status and command port.
// Assumes psc_consts.svh is compiled alongside.
package psc_pkg;
  // ==========================================================
  // Mechanism states
  typedef enum logic [2:0] {
    PSC_IDLE = 3'b000,
    PSC_WHEEL = 3'b001,
    PSC_HAMMER = 3'b010,
    PSC_RIBBON = 3'b011,
    PSC_CARR = 3'b100,
    PSC_PAPER = 3'b101,
    PSC_RESTORE = 3'b110
  } psc_state_t;
endpackage

// ---- psc_motion.sv ----
// Motion step timer: counts a move magnitude down at one step per period.
// Assumes the caller starts it only when idle.
`timescale 1ns/100ps
`default_nettype none
module psc_motion #(
  parameter int W = 12
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic start_i, // Load a new magnitude
  input wire logic abort_i, // Drop the move
  input wire logic [W-1:0] mag_i, // Steps to travel
  input wire logic [15:0] step_cyc_i, // Clocks per step, less one
  output logic busy_o // Move in progress
);
  logic [W-1:0] left_q;
  logic [15:0] tick_q;
  // ==========================================================
  // Step counting; a zero magnitude still takes one step period
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || abort_i) begin
      left_q <= '0;
      tick_q <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      left_q <= mag_i;
      tick_q <= step_cyc_i;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (tick_q > 16'h0000) begin
        tick_q <= tick_q - 16'h0001;
      end else if (left_q != '0) begin
        left_q <= left_q - W'(1);
        tick_q <= step_cyc_i;
      end else begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- psc_port.sv ----
// Printer-side command and status port with an AXI4-Lite register file.
// Assumes strobes are synchronous, active low, and held at least 500 ns.
`timescale 1ns/100ps
`default_nettype none
`include "psc_consts.svh"
// Notes on behaviour
// - Restore aborts all work, clears faults, returns carriage leftmost.
// - Ribbon raise low lifts the ribbon up.
// - Ribbon raise high keeps the ribbon down.
// - Ribbon motion and printing never overlap; running one finishes first.
// - Fault asserts on malfunction or illegal command.
// - During fault, mechanics halt and all but restore are ignored.
// - Fault stays latched until restore or power cycle.
// - Character ready low when a print may start, high while printing.
// - Character ready held high while ribbon is exhausted.
// - Carriage ready high while carriage moves.
// - Right paper ready high while platen moves.
// - Left paper ready always high.
// - Printer ready only when selected, powered and malfunction free.
// - Printer ready high during restore.
// - Commands other than restore, and status, only act while select is low.
// - Print rotates wheel, hammer fires after all motion stops.
// - Carriage move in 1/120 inch units, direction bit high moves right.
// - Paper move in 1/48 inch units, direction bit high advances.
module psc_port (
  input wire logic clk_sys_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset
  input wire logic select_n_i, // Printer select, low true
  input wire logic [11:0] data_i, // Command data lines
  input wire logic char_stb_n_i, // Character strobe
  input wire logic carr_stb_n_i, // Carriage strobe
  input wire logic paper_stb_n_i, // Right paper strobe
  input wire logic restore_n_i, // Restore strobe
  input wire logic ribbon_raise_n_i, // Ribbon raise, low true
  output logic char_rdy_n_o, // Character ready
  output logic carr_rdy_n_o, // Carriage ready
  output logic paper_r_rdy_n_o, // Paper right ready
  output logic paper_l_rdy_n_o, // Paper left ready
  output logic prn_rdy_n_o, // Printer ready
  output logic fault_n_o, // Fault line
  output logic ribbon_up_o, // Ribbon actuator up
  output logic carr_dir_right_o, // Carriage direction of last move
  output logic paper_dir_adv_o, // Paper direction of last move
  output logic [6:0] wheel_char_o, // Selected wheel character
  output logic hammer_o, // Hammer fire pulse
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read response valid
  input wire logic s_axi_rready // AXI read response ready
);
  psc_pkg::psc_state_t state_q;
  logic [2:0] ctrl_q;
  logic [15:0] step_cyc_q;
  logic fault_q, illegal_q, restore_q, rib_up_q;
  logic [7:0] rst_cnt_q;
  logic char_stb_q, carr_stb_q, paper_stb_q;
  logic char_go, carr_go, paper_go, restore_go;
  logic carr_busy, paper_busy, wheel_busy, selected, ribbon_want;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // True when a strobe was high last cycle and low now
  function automatic logic fall(input logic prev, input logic now);
    return prev && !now;
  endfunction

  // ==========================================================
  // Strobe edges; restore ungated, the others gated by select and fault
  assign selected = !select_n_i;
  assign restore_go = fall(restore_q, restore_n_i);
  assign char_go = fall(char_stb_q, char_stb_n_i) && selected && !fault_q;
  assign carr_go = fall(carr_stb_q, carr_stb_n_i) && selected && !fault_q;
  assign paper_go = fall(paper_stb_q, paper_stb_n_i) && selected && !fault_q;
  assign ribbon_want = !ribbon_raise_n_i;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      char_stb_q <= 1'b1;
      carr_stb_q <= 1'b1;
      paper_stb_q <= 1'b1;
      restore_q <= 1'b1;
    end else begin
      char_stb_q <= char_stb_n_i;
      carr_stb_q <= carr_stb_n_i;
      paper_stb_q <= paper_stb_n_i;
      restore_q <= restore_n_i;
    end
  end

  // ==========================================================
  // Motion timers; fault aborts all three, restore aborts carriage and paper
  psc_motion #(.W(12)) u_carr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(carr_go && state_q == psc_pkg::PSC_IDLE),
    .abort_i(restore_go || fault_q),
    .mag_i(data_i & `PSC_CARR_MAX),
    .step_cyc_i(step_cyc_q),
    .busy_o(carr_busy)
  );
  psc_motion #(.W(12)) u_paper (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(paper_go && state_q == psc_pkg::PSC_IDLE),
    .abort_i(restore_go || fault_q),
    .mag_i(data_i & `PSC_PAPR_MAX),
    .step_cyc_i(step_cyc_q),
    .busy_o(paper_busy)
  );
  psc_motion #(.W(7)) u_wheel (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i((char_go && state_q == psc_pkg::PSC_IDLE && !ctrl_q[`PSC_CTRL_RIB_EXH])
             || (restore_go && !fault_q) || (state_q == psc_pkg::PSC_RESTORE && rst_cnt_q == 8'h01)),
    .abort_i(fault_q),
    .mag_i(data_i[`PSC_CHAR_MSB:0]),
    .step_cyc_i(step_cyc_q),
    .busy_o(wheel_busy)
  );

  // ==========================================================
  // Mechanism sequencer; one activity at a time gives the ribbon interlock
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= psc_pkg::PSC_RESTORE; // Power-up runs a restore
      rst_cnt_q <= 8'(`PSC_RESTORE_MIN_CYC);
      rib_up_q <= 1'b0;
      hammer_o <= 1'b0;
      wheel_char_o <= 7'h00;
      carr_dir_right_o <= 1'b0;
      paper_dir_adv_o <= 1'b0;
    end else begin
      hammer_o <= 1'b0;
      if (restore_go) begin
        state_q <= psc_pkg::PSC_RESTORE;
        rst_cnt_q <= 8'(`PSC_RESTORE_MIN_CYC);
        carr_dir_right_o <= 1'b0;
      end else if (fault_q) begin
        state_q <= psc_pkg::PSC_IDLE;
      end else begin
        case (state_q)
          psc_pkg::PSC_IDLE: begin
            if (char_go && !ctrl_q[`PSC_CTRL_RIB_EXH]) begin
              wheel_char_o <= data_i[`PSC_CHAR_MSB:0];
              state_q <= psc_pkg::PSC_WHEEL;
            end else if (carr_go) begin
              carr_dir_right_o <= data_i[`PSC_DIR_BIT];
              state_q <= psc_pkg::PSC_CARR;
            end else if (paper_go) begin
              paper_dir_adv_o <= data_i[`PSC_DIR_BIT];
              state_q <= psc_pkg::PSC_PAPER;
            end else if (selected && ribbon_want != rib_up_q) begin
              rib_up_q <= ribbon_want;
              state_q <= psc_pkg::PSC_RIBBON;
            end
          end
          psc_pkg::PSC_WHEEL: begin
            if (!wheel_busy && !carr_busy && !paper_busy) begin
              hammer_o <= 1'b1;
              state_q <= psc_pkg::PSC_HAMMER;
            end
          end
          psc_pkg::PSC_HAMMER: state_q <= psc_pkg::PSC_IDLE;
          psc_pkg::PSC_RIBBON: state_q <= psc_pkg::PSC_IDLE;
          psc_pkg::PSC_CARR: if (!carr_busy) state_q <= psc_pkg::PSC_IDLE;
          psc_pkg::PSC_PAPER: if (!paper_busy) state_q <= psc_pkg::PSC_IDLE;
          psc_pkg::PSC_RESTORE: begin
            if (rst_cnt_q != 8'h00) begin
              rst_cnt_q <= rst_cnt_q - 8'h01;
            end else if (!wheel_busy) begin
              state_q <= psc_pkg::PSC_IDLE;
            end
          end
          default: state_q <= psc_pkg::PSC_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Fault latch; only restore or reset clears, a new cause wins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (ctrl_q[`PSC_CTRL_MALF] || illegal_q) begin
      fault_q <= 1'b1;
    end else if (restore_go) begin
      fault_q <= 1'b0;
    end
  end

  // Strobe refused because the mechanism is busy outside restore counts as illegal
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= (char_go || carr_go || paper_go) && state_q != psc_pkg::PSC_IDLE
                   && state_q != psc_pkg::PSC_RESTORE && !restore_go;
    end
  end

  // ==========================================================
  // Ready lines, low true and gated by select and fault
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      char_rdy_n_o <= 1'b1;
      carr_rdy_n_o <= 1'b1;
      paper_r_rdy_n_o <= 1'b1;
      prn_rdy_n_o <= 1'b1;
      fault_n_o <= 1'b1;
    end else begin
      char_rdy_n_o <= !(selected && !fault_q && state_q == psc_pkg::PSC_IDLE
                        && !ctrl_q[`PSC_CTRL_RIB_EXH]);
      carr_rdy_n_o <= !(selected && !fault_q && !carr_busy && state_q == psc_pkg::PSC_IDLE);
      paper_r_rdy_n_o <= !(selected && !fault_q && !paper_busy && state_q == psc_pkg::PSC_IDLE);
      prn_rdy_n_o <= !(selected && ctrl_q[`PSC_CTRL_POWER_OK] && !ctrl_q[`PSC_CTRL_MALF]
                       && !fault_q && state_q != psc_pkg::PSC_RESTORE);
      fault_n_o <= !(selected && fault_q);
    end
  end
  assign paper_l_rdy_n_o = 1'b1;
  assign ribbon_up_o = rib_up_q;

  // ==========================================================
  // AXI4-Lite write channel; address and data taken in any order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSC_AXI_OKAY;
      ctrl_q <= 3'b001;
      step_cyc_q <= `PSC_STEP_CYC_DEF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PSC_AXI_OKAY;
        case (awaddr_q)
          `PSC_ADDR_CTRL: if (wstrb_q[0]) ctrl_q <= wdata_q[2:0];
          `PSC_ADDR_TIME: begin
            if (wstrb_q[0]) step_cyc_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) step_cyc_q[15:8] <= wdata_q[15:8];
          end
          `PSC_ADDR_STAT, `PSC_ADDR_CMD: ;
          default: s_axi_bresp <= `PSC_AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel; status shows the ready pins as driven and the fault latch high true
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSC_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PSC_AXI_OKAY;
      case (s_axi_araddr)
        `PSC_ADDR_CTRL: s_axi_rdata <= {29'h0, ctrl_q};
        `PSC_ADDR_STAT: s_axi_rdata <= {24'h0, state_q == psc_pkg::PSC_RESTORE, rib_up_q, fault_q,
                                        prn_rdy_n_o, paper_l_rdy_n_o, paper_r_rdy_n_o,
                                        carr_rdy_n_o, char_rdy_n_o};
        `PSC_ADDR_CMD: s_axi_rdata <= {20'h0, wheel_char_o, carr_dir_right_o, paper_dir_adv_o, state_q};
        `PSC_ADDR_TIME: s_axi_rdata <= {16'h0, step_cyc_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `PSC_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- psc_port_chk_assertions.sv ----
// Port-level timing checker for the printer command and status port.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module psc_port_chk (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic select_n_i, // Select
  input wire logic char_stb_n_i, // Char strobe
  input wire logic carr_stb_n_i, // Carriage strobe
  input wire logic paper_stb_n_i, // Paper strobe
  input wire logic restore_n_i, // Restore strobe
  input wire logic ribbon_raise_n_i, // Ribbon raise
  input wire logic char_rdy_n_o, // Char ready
  input wire logic carr_rdy_n_o, // Carriage ready
  input wire logic paper_r_rdy_n_o, // Paper ready
  input wire logic paper_l_rdy_n_o, // Left ready
  input wire logic prn_rdy_n_o, // Printer ready
  input wire logic fault_n_o, // Fault
  input wire logic ribbon_up_o, // Ribbon up
  input wire logic hammer_o // Hammer
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // =====
  // Strobe taken with the mechanism idle; busy strobes outside restore are faults instead
  sequence s_go(stb);
    $fell(stb) && !select_n_i && fault_n_o && !char_rdy_n_o && !carr_rdy_n_o && !paper_r_rdy_n_o;
  endsequence
  property p_char;
    s_go(char_stb_n_i) |-> ##[1:2] char_rdy_n_o;
  endproperty
  a_char: assert property (p_char) else $error("char ready stayed low");
  property p_carr;
    s_go(carr_stb_n_i) |-> ##[1:2] carr_rdy_n_o;
  endproperty
  a_carr: assert property (p_carr) else $error("carriage ready stayed low");
  property p_paper;
    s_go(paper_stb_n_i) |-> ##[1:2] paper_r_rdy_n_o;
  endproperty
  a_paper: assert property (p_paper) else $error("paper ready stayed low");
  property p_left;
    paper_l_rdy_n_o;
  endproperty
  a_left: assert property (p_left) else $error("left ready went low");
  property p_sel;
    select_n_i ##1 select_n_i |-> prn_rdy_n_o;
  endproperty
  a_sel: assert property (p_sel) else $error("ready while deselected");
  property p_rest;
    $fell(restore_n_i) |-> ##[1:2] prn_rdy_n_o;
  endproperty
  a_rest: assert property (p_rest) else $error("ready during restore");
  // Hammer only strikes mid print, with the ribbon at rest and no fault standing
  property p_hammer;
    hammer_o |-> char_rdy_n_o && $stable(ribbon_up_o) && fault_n_o;
  endproperty
  a_hammer: assert property (p_hammer) else $error("hammer out of turn");
  property p_hold;
    !fault_n_o && !select_n_i && restore_n_i && $past(restore_n_i) |=> !fault_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("fault cleared alone");
  property p_rib;
    $changed(ribbon_raise_n_i) && fault_n_o && !select_n_i |-> ##[1:1000] (ribbon_up_o != ribbon_raise_n_i || !fault_n_o);
  endproperty
  a_rib: assert property (p_rib) else $error("ribbon did not follow");
  property p_back;
    $rose(carr_rdy_n_o) && fault_n_o |-> ##[1:1000] (!carr_rdy_n_o || !fault_n_o || select_n_i);
  endproperty
  a_back: assert property (p_back) else $error("carriage ready stuck");
endmodule
bind psc_port psc_port_chk i_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .select_n_i(select_n_i),
  .char_stb_n_i(char_stb_n_i), .carr_stb_n_i(carr_stb_n_i), .paper_stb_n_i(paper_stb_n_i),
  .restore_n_i(restore_n_i), .ribbon_raise_n_i(ribbon_raise_n_i), .char_rdy_n_o(char_rdy_n_o),
  .carr_rdy_n_o(carr_rdy_n_o), .paper_r_rdy_n_o(paper_r_rdy_n_o), .paper_l_rdy_n_o(paper_l_rdy_n_o),
  .prn_rdy_n_o(prn_rdy_n_o), .fault_n_o(fault_n_o), .ribbon_up_o(ribbon_up_o), .hammer_o(hammer_o));
`default_nettype wire

// ---- psc_ctl_model.sv ----
// Controller board model driving the printer strobe and command lines.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module psc_ctl_model (
  input wire logic clk_sys_i, // Clock
  output logic select_n_o, // Select
  output logic [11:0] data_o, // Data lines
  output logic char_stb_n_o, // Char strobe
  output logic carr_stb_n_o, // Carriage strobe
  output logic paper_stb_n_o, // Paper strobe
  output logic restore_n_o, // Restore strobe
  output logic ribbon_raise_n_o // Ribbon raise
);
  // =====
  // Idle levels
  initial begin
    select_n_o = 1'b0;
    data_o = 12'h000;
    {char_stb_n_o, carr_stb_n_o, paper_stb_n_o, restore_n_o} = 4'hf;
    ribbon_raise_n_o = 1'b1;
  end
  // 200 ns data setup, 500 ns strobe; released data is inverted so it is not mistaken for held
  task automatic pulse(input int k, input logic [11:0] d);
    data_o <= d;
    repeat (8) @(posedge clk_sys_i);
    {char_stb_n_o, carr_stb_n_o, paper_stb_n_o, restore_n_o} <= ~(4'h8 >> k);
    repeat (20) @(posedge clk_sys_i);
    {char_stb_n_o, carr_stb_n_o, paper_stb_n_o, restore_n_o} <= 4'hf;
    data_o <= ~d;
    @(posedge clk_sys_i);
  endtask
  task automatic sel(input logic v);
    select_n_o <= v;
    @(posedge clk_sys_i);
  endtask
  task automatic rib(input logic v);
    ribbon_raise_n_o <= v;
    @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the printer command and status port.
// Assumes the controller model and bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "psc_consts.svh"
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_i;
  logic sel_n, c_stb, k_stb, p_stb, r_stb, rib_n, char_rdy_n, carr_rdy_n, paper_r_n, paper_l_n, prn_rdy_n, fault_n;
  logic rib_up, carr_dir, paper_dir, hammer, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [6:0] wheel;
  logic [11:0] data;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int bad_count = 0;
  int n_checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  psc_ctl_model i_ctl (.clk_sys_i(clk_sys_i), .select_n_o(sel_n), .data_o(data), .char_stb_n_o(c_stb),
    .carr_stb_n_o(k_stb), .paper_stb_n_o(p_stb), .restore_n_o(r_stb), .ribbon_raise_n_o(rib_n));
  psc_port i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .select_n_i(sel_n), .data_i(data), .char_stb_n_i(c_stb),
    .carr_stb_n_i(k_stb), .paper_stb_n_i(p_stb), .restore_n_i(r_stb), .ribbon_raise_n_i(rib_n),
    .char_rdy_n_o(char_rdy_n), .carr_rdy_n_o(carr_rdy_n), .paper_r_rdy_n_o(paper_r_n), .paper_l_rdy_n_o(paper_l_n),
    .prn_rdy_n_o(prn_rdy_n), .fault_n_o(fault_n), .ribbon_up_o(rib_up), .carr_dir_right_o(carr_dir),
    .paper_dir_adv_o(paper_dir), .wheel_char_o(wheel), .hammer_o(hammer), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // =====
  // Reporting
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chkw({31'h0, g}, {31'h0, e});
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return char_rdy_n;
      1: return carr_rdy_n;
      2: return paper_r_n;
      3: return prn_rdy_n;
      4: return fault_n;
      5: return rib_up;
      default: return hammer;
    endcase
  endfunction
  // Bounded wait for a pin level; running out ends the run
  task automatic wt(input int k, input logic v);
    int n;
    for (n = 0; n < 3000 && sig(k) !== v; n++) @(posedge clk_sys_i);
    chk1(sig(k), v);
    if (n == 3000) results();
  endtask
  // =====
  // AXI4-Lite master: address and data offered together, answer awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic got;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        bready <= 1'b0;
        chkw({30'h0, bresp}, {30'h0, e});
      end
    end
    // A missing answer is a failure, never a silent pass
    if (!got) begin
      bad_count++;
      results();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    logic got;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        rready <= 1'b0;
        chkw(rdata, e);
        chkw({30'h0, rresp}, (a > `PSC_ADDR_TIME) ? {30'h0, `PSC_AXI_SLVERR} : {30'h0, `PSC_AXI_OKAY});
      end
    end
    if (!got) begin
      bad_count++;
      results();
    end
    @(posedge clk_sys_i);
  endtask
  // =====
  // Scenarios
  task automatic t_regs();
    rd(`PSC_ADDR_CTRL, 32'h0000_0001);
    rd(`PSC_ADDR_STAT, 32'h0000_0008);
    rd(`PSC_ADDR_TIME, 32'h0000_0004);
    // Only byte lane 0 enabled: the upper byte of the step count must not change
    wstrb <= 4'h1;
    wr(`PSC_ADDR_TIME, 32'h0000_0304, `PSC_AXI_OKAY);
    wstrb <= 4'hf;
    rd(`PSC_ADDR_TIME, 32'h0000_0004);
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000, `PSC_AXI_SLVERR);
    chk1(paper_l_n, 1'b1);
    wr(`PSC_ADDR_CTRL, 32'h0000_0003, `PSC_AXI_OKAY);
    wt(0, 1'b1);
    rd(`PSC_ADDR_CTRL, 32'h0000_0003);
    wr(`PSC_ADDR_CTRL, 32'h0000_0001, `PSC_AXI_OKAY);
    wt(0, 1'b0);
    $display("registers done");
  endtask
  // Ribbon dropped mid print must wait for the hammer
  task automatic t_print();
    i_ctl.rib(1'b0);
    wt(5, 1'b1);
    i_ctl.pulse(0, 12'h041);
    i_ctl.rib(1'b1);
    chk1(char_rdy_n, 1'b1);
    wt(6, 1'b1);
    chk1(rib_up, 1'b1);
    chkw({25'h0, wheel}, 32'h0000_0041);
    wt(0, 1'b0);
    wt(5, 1'b0);
    $display("print done");
  endtask
  task automatic t_motion();
    i_ctl.pulse(1, 12'h045);
    chk1(carr_rdy_n, 1'b1);
    chk1(carr_dir, 1'b1);
    wt(1, 1'b0);
    i_ctl.pulse(1, 12'h005);
    chk1(carr_dir, 1'b0);
    wt(1, 1'b0);
    i_ctl.pulse(2, 12'h005);
    chk1(paper_r_n, 1'b1);
    chk1(paper_dir, 1'b0);
    wt(2, 1'b0);
    i_ctl.pulse(2, 12'h042);
    chk1(paper_dir, 1'b1);
    wt(2, 1'b0);
    $display("motion done");
  endtask
  // Illegal strobe while moving, then malfunction; only restore clears
  task automatic t_fault();
    i_ctl.pulse(1, 12'h0C8);
    i_ctl.pulse(0, 12'h041);
    wt(4, 1'b0);
    i_ctl.rib(1'b0);
    repeat (40) @(posedge clk_sys_i);
    chk1(rib_up, 1'b0);
    chk1(fault_n, 1'b0);
    fork
      i_ctl.pulse(3, 12'h000);
      begin
        repeat (12) @(posedge clk_sys_i);
        chk1(prn_rdy_n, 1'b1);
      end
    join
    wt(4, 1'b1);
    chk1(carr_dir, 1'b0);
    wt(3, 1'b0);
    i_ctl.rib(1'b1);
    wt(5, 1'b0);
    wr(`PSC_ADDR_CTRL, 32'h0000_0005, `PSC_AXI_OKAY);
    wt(4, 1'b0);
    wt(3, 1'b1);
    wr(`PSC_ADDR_CTRL, 32'h0000_0001, `PSC_AXI_OKAY);
    repeat (5) @(posedge clk_sys_i);
    chk1(fault_n, 1'b0);
    i_ctl.pulse(3, 12'h000);
    wt(4, 1'b1);
    wt(3, 1'b0);
    $display("fault done");
  endtask
  task automatic t_select();
    i_ctl.sel(1'b1);
    i_ctl.pulse(1, 12'h045);
    chk1(prn_rdy_n, 1'b1);
    i_ctl.sel(1'b0);
    wt(1, 1'b0);
    chk1(carr_dir, 1'b0);
    wt(3, 1'b0);
    $display("select done");
  endtask
  // =====
  // Main sequence
  initial begin
    {rst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hf};
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    wt(3, 1'b0);
    t_regs();
    t_print();
    t_motion();
    t_fault();
    t_select();
    results();
  end
endmodule
`default_nettype wire
